// ==== logic/dcde_pkg.sv ====
package dcde_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned TICK_CYC     = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned LOGIC_US     = 4000;
  localparam int unsigned LOGIC_CYC    = LOGIC_US * CLK_MHZ;
  localparam int unsigned DISC_MAX_MS  = 30000;
  localparam int unsigned DISC_MAX_TK  = DISC_MAX_MS / TICK_MS;
  localparam int unsigned TMR_W        = 12;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_DISC    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_INPUTS  = 8'h0C;

  localparam int unsigned CTRL_MODE    = 0;
  localparam int unsigned CTRL_TWO_OUT = 1;
  localparam int unsigned CTRL_SAME    = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h2;
  localparam logic [TMR_W-1:0] DISC_RST = 12'h000;

  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ENABLE    = 2;
  localparam int unsigned ST_DERR      = 3;
  localparam int unsigned ST_FAULT     = 4;
  localparam int unsigned ST_ARMED     = 5;
  localparam int unsigned ST_RUN       = 6;
  localparam int unsigned ST_TMR_LSB   = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCDE_DEACT  = 2'b00,
    DCDE_DISC   = 2'b01,
    DCDE_ACTIVE = 2'b10,
    DCDE_ERROR  = 2'b11
  } dcde_state_t;

  typedef enum logic {
    DCDE_EQUIV = 1'b0,
    DCDE_COMPL = 1'b1
  } dcde_mode_t;

endpackage

// ==== logic/dcde_div.sv ====
`timescale 1ns/1ps

module dcde_div #(
  parameter int unsigned DIV = 10
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_q;

  generate
    if (DIV < 1) begin : g_bad_div
      $error("dcde_div: DIV must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Tick stays a single cycle wide so every consumer counts it once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == W'(DIV - 1));
    end
  end

endmodule

// ==== logic/dcde_eval.sv ====
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Equivalent: 00 off, mixed discrepant, 11 active
// [R2] Complementary: 01 off, equal discrepant, 10 active
// [R3] Discrepancy time is software configurable
// [R4] Timeout forces error, enable low, error high
// [R5] Timer restarts on first change into discrepant
// [R6] Zero discrepancy time never starts the timer
// [R7] Error output held while off or discrepant
// [R8] Active needs an off state since last active
// [R9] Active only before timeout with correct sequence
// [R10] Reaching active clears the latched error
// [R11] Wrong combination or order raises fault output
// [R12] Configurer picks time above logic cycle
// [R13] Timing accurate to one tick plus cycle
// [R14] Tested sensors need time above test gap
// [R15] Same source pair acts as single channel
// [R16] Time is zero or 10 to 30000 ms
// [R17] One or two outputs option
// [R18] Evaluate once per logic cycle, 10 ms ticks
// [R19] Reset: timer stopped, outputs low
module dcde_eval #(
  parameter int unsigned TICK_CYCLES  = dcde_pkg::TICK_CYC,
  parameter int unsigned LOGIC_CYCLES = dcde_pkg::LOGIC_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        in_a,
  input  wire logic        in_b,
  output logic             enable_o,
  output logic             disc_err_o,
  output logic             fault_o,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int unsigned TW = dcde_pkg::TMR_W;

  generate
    if (TICK_CYCLES < 1 || LOGIC_CYCLES < 1) begin : g_bad_par
      $error("dcde_eval: divider counts must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 a_meta_q;
  logic                 a_sync_q;
  logic                 b_meta_q;
  logic                 b_sync_q;
  logic                 a_q;
  logic                 b_q;
  logic                 tick_en;
  logic                 lc_en;
  logic [2:0]           ctrl_q;
  logic [TW-1:0]        disc_q;
  dcde_pkg::dcde_state_t state_q;
  dcde_pkg::dcde_state_t state_d;
  dcde_pkg::dcde_state_t cls;
  logic                 armed_q;
  logic                 armed_d;
  logic                 en_q;
  logic                 en_d;
  logic                 derr_q;
  logic                 derr_d;
  logic                 fault_q;
  logic                 fault_d;
  logic                 run_q;
  logic [TW-1:0]        tmr_q;
  logic                 tmr_start;
  logic                 tmr_stop;
  logic                 timeout;
  logic                 timing_on;
  logic                 same_src;
  dcde_pkg::dcde_mode_t mode;
  logic                 wr_acc;
  logic                 rd_setup;
  logic                 in_vld_q;
  logic                 lc_eval;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Sensor lines are asynchronous to clk, so each passes two flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_meta_q <= 1'b0;
      a_sync_q <= 1'b0;
      b_meta_q <= 1'b0;
      b_sync_q <= 1'b0;
    end else begin
      a_meta_q <= in_a;
      a_sync_q <= a_meta_q;
      b_meta_q <= in_b;
      b_sync_q <= b_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  dcde_div #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick_en)
  );

  dcde_div #(
    .DIV (LOGIC_CYCLES)
  ) u_lcyc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (lc_en)
  );

  // Inputs are frozen per logic cycle, as the controller samples them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_q      <= 1'b0;
      b_q      <= 1'b0;
      in_vld_q <= 1'b0;
    end else if (lc_en) begin // [R18]
      a_q      <= a_sync_q;
      b_q      <= b_sync_q;
      in_vld_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  function automatic dcde_pkg::dcde_state_t classify(
    input dcde_pkg::dcde_mode_t m,
    input logic                 sa,
    input logic                 a,
    input logic                 b
  );
    dcde_pkg::dcde_state_t c;
    c = dcde_pkg::DCDE_DISC;
    if (sa) begin
      // Single channel: channel A alone decides
      c = a ? dcde_pkg::DCDE_ACTIVE : dcde_pkg::DCDE_DEACT; // [R15]
    end else if (m == dcde_pkg::DCDE_EQUIV) begin
      if (!a && !b) begin
        c = dcde_pkg::DCDE_DEACT; // [R1]
      end else if (a && b) begin
        c = dcde_pkg::DCDE_ACTIVE; // [R1]
      end
    end else begin
      if (!a && b) begin
        c = dcde_pkg::DCDE_DEACT; // [R2]
      end else if (a && !b) begin
        c = dcde_pkg::DCDE_ACTIVE; // [R2]
      end
    end
    return c;
  endfunction

  assign mode      = dcde_pkg::dcde_mode_t'(ctrl_q[dcde_pkg::CTRL_MODE]);
  assign same_src  = ctrl_q[dcde_pkg::CTRL_SAME];
  assign cls       = classify(mode, same_src, a_q, b_q);
  assign timing_on = (disc_q != '0) && !same_src; // [R6] [R15]
  assign timeout   = run_q && timing_on && (tmr_q >= disc_q); // [R4]
  // Reset zeros in a_q/b_q are no real off state, so they may not arm
  assign lc_eval   = lc_en && in_vld_q; // [R8]

  // ----------------------------------------------------------------
  // Evaluation
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    armed_d   = armed_q;
    en_d      = 1'b0;
    derr_d    = derr_q; // [R7]
    fault_d   = fault_q;
    tmr_start = 1'b0;
    tmr_stop  = 1'b0;
    case (state_q)
      dcde_pkg::DCDE_ERROR: begin
        // Error persists until the pair returns to its off state
        if (cls == dcde_pkg::DCDE_DEACT) begin
          state_d  = dcde_pkg::DCDE_DEACT;
          armed_d  = 1'b1;
          tmr_stop = 1'b1;
        end
      end
      default: begin
        if (timeout) begin
          state_d  = dcde_pkg::DCDE_ERROR; // [R4]
          derr_d   = 1'b1; // [R4]
          fault_d  = 1'b1; // [R11]
          tmr_stop = 1'b1;
        end else begin
          case (cls)
            dcde_pkg::DCDE_DEACT: begin
              state_d  = dcde_pkg::DCDE_DEACT;
              armed_d  = 1'b1; // [R8]
              tmr_stop = 1'b1;
            end
            dcde_pkg::DCDE_ACTIVE: begin
              // Holding the pair active is no new activation
              if (armed_q || state_q == dcde_pkg::DCDE_ACTIVE) begin
                state_d  = dcde_pkg::DCDE_ACTIVE; // [R9]
                en_d     = 1'b1;
                derr_d   = 1'b0; // [R10]
                fault_d  = 1'b0;
                armed_d  = 1'b0; // [R8]
                tmr_stop = 1'b1;
              end else begin
                // Active pattern without an off state is a bad sequence
                state_d = dcde_pkg::DCDE_DISC; // [R8]
                fault_d = 1'b1; // [R11]
                if (state_q != dcde_pkg::DCDE_DISC && timing_on) begin
                  tmr_start = 1'b1; // [R5]
                end
              end
            end
            default: begin
              state_d = dcde_pkg::DCDE_DISC;
              if (state_q != dcde_pkg::DCDE_DISC && timing_on) begin
                tmr_start = 1'b1; // [R5]
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= dcde_pkg::DCDE_DEACT;
      armed_q <= 1'b0;
    end else if (lc_eval) begin // [R18]
      state_q <= state_d;
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q    <= 1'b0; // [R19]
      derr_q  <= 1'b0; // [R19]
      fault_q <= 1'b0;
    end else if (lc_eval) begin
      en_q    <= en_d;
      derr_q  <= derr_d;
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------------------------------
  // Discrepancy timer
  // ----------------------------------------------------------------
  // Counts whole ticks, so a timeout lands within one tick plus one
  // logic cycle of the set time; saturates rather than wrapping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= 1'b0; // [R19]
      tmr_q <= '0;
    end else if (lc_eval && tmr_start) begin
      run_q <= 1'b1; // [R5]
      tmr_q <= '0;
    end else if (lc_eval && tmr_stop) begin
      run_q <= 1'b0;
      tmr_q <= '0;
    end else if (tick_en && run_q && tmr_q != '1) begin
      tmr_q <= tmr_q + 1'b1; // [R13] [R18]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_o   <= 1'b0;
      disc_err_o <= 1'b0;
      fault_o    <= 1'b0;
    end else begin
      enable_o   <= en_q && (state_q == dcde_pkg::DCDE_ACTIVE);
      disc_err_o <= derr_q && ctrl_q[dcde_pkg::CTRL_TWO_OUT]; // [R17]
      fault_o    <= fault_q; // [R11]
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  function automatic logic mapped(input logic [7:0] adr);
    return adr == dcde_pkg::ADDR_CTRL   || adr == dcde_pkg::ADDR_DISC ||
           adr == dcde_pkg::ADDR_STATUS || adr == dcde_pkg::ADDR_INPUTS;
  endfunction

  assign pslverr = psel && penable && !mapped(paddr);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= dcde_pkg::CTRL_RST;
    end else if (wr_acc && paddr == dcde_pkg::ADDR_CTRL) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // Values above the legal span are clamped to the top setting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disc_q <= dcde_pkg::DISC_RST;
    end else if (wr_acc && paddr == dcde_pkg::ADDR_DISC) begin
      if (pwdata[31:0] > dcde_pkg::DISC_MAX_TK) begin
        disc_q <= TW'(dcde_pkg::DISC_MAX_TK); // [R3] [R16]
      end else begin
        disc_q <= pwdata[TW-1:0]; // [R3]
      end
    end
  end

  // Read data is captured in the setup cycle and shown in the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        dcde_pkg::ADDR_CTRL: begin
          prdata[2:0] <= ctrl_q;
        end
        dcde_pkg::ADDR_DISC: begin
          prdata[TW-1:0] <= disc_q;
        end
        dcde_pkg::ADDR_STATUS: begin
          prdata[dcde_pkg::ST_STATE_LSB +: 2] <= state_q;
          prdata[dcde_pkg::ST_ENABLE]         <= en_q;
          prdata[dcde_pkg::ST_DERR]           <= derr_q;
          prdata[dcde_pkg::ST_FAULT]          <= fault_q;
          prdata[dcde_pkg::ST_ARMED]          <= armed_q;
          prdata[dcde_pkg::ST_RUN]            <= run_q;
          prdata[dcde_pkg::ST_TMR_LSB +: TW]  <= tmr_q;
        end
        dcde_pkg::ADDR_INPUTS: begin
          prdata[0] <= a_q;
          prdata[1] <= b_q;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// ==== verif/dcde_eval_checker.sv ====
`timescale 1ns/1ps

module dcde_eval_checker #(
  parameter int unsigned TICK_CYCLES  = 10,
  parameter int unsigned LOGIC_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        in_a,
  input wire logic        in_b,
  input wire logic        enable_o,
  input wire logic        disc_err_o,
  input wire logic        fault_o,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ------------------------------------------------------------
  // Pin history
  // ------------------------------------------------------------
  // Counters saturate so a long idle pin never wraps into a pass
  logic [15:0] lo_cnt_q;
  logic [15:0] hi_cnt_q;
  logic        apb_wr;
  int unsigned lo_lim;
  assign apb_wr = psel && penable && pwrite;
  assign lo_lim = 3 * LOGIC_CYCLES + 4;
  always_ff @(posedge clk) begin
    if (sys_rst || in_a) lo_cnt_q <= 16'h0000;
    else if (lo_cnt_q != 16'hFFFF) lo_cnt_q <= lo_cnt_q + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || !in_a) hi_cnt_q <= 16'h0000;
    else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_rst_quiet: assert property ($fell(sys_rst) |->
    (!enable_o && !disc_err_o && !fault_o) [*4])
    else $error("outputs not quiet after reset");
  a_en_after_a: assert property ($rose(enable_o) |->
    hi_cnt_q >= 16'h0003) else $error("enable rose without channel A");
  a_en_a_low: assert property ({16'h0000, lo_cnt_q} >= lo_lim |->
    !enable_o) else $error("enable held with channel A low");
  a_en_no_err: assert property (enable_o |->
    !disc_err_o && !fault_o) else $error("error seen while enabled");
  a_err_rise: assert property ($rose(disc_err_o) |->
    !enable_o && fault_o) else $error("error rose without fault");
  a_err_hold: assert property ($fell(disc_err_o) |->
    enable_o || $past(apb_wr) || $past(apb_wr, 2))
    else $error("error dropped without activation");
  a_fault_hold: assert property ($fell(fault_o) |->
    $rose(enable_o)) else $error("fault dropped without activation");
  a_bus_ready: assert property (psel && penable |->
    pready) else $error("access phase without ready");
  a_unmapped_rd: assert property (psel && penable && !pwrite &&
    paddr > 8'h0C |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (psel && penable &&
    paddr <= 8'h0C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");

  c_enable: cover property ($rose(enable_o));
  c_timeout: cover property ($rose(disc_err_o));
  c_fault: cover property ($rose(fault_o) && !disc_err_o);
  c_refused: cover property (pslverr);
endmodule

bind dcde_eval dcde_eval_checker #(
  .TICK_CYCLES(TICK_CYCLES), .LOGIC_CYCLES(LOGIC_CYCLES)
) u_chk (
  .clk(clk), .sys_rst(sys_rst), .in_a(in_a), .in_b(in_b),
  .enable_o(enable_o), .disc_err_o(disc_err_o), .fault_o(fault_o),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ==== verif/dcde_pair_model.sv ====
`timescale 1ns/1ps

// --------------------------------------------------------------
// Redundant sensor pair
// --------------------------------------------------------------
// Channel B trails A by a set lag, as two contacts rarely part
// together; the bench keeps the lag well below the timeout.
module dcde_pair_model (
  input  wire logic       clk,
  input  wire logic       cmd_a,
  input  wire logic       cmd_b,
  input  wire logic [7:0] lag,
  output logic            in_a,
  output logic            in_b
);
  logic [7:0] cnt_q;
  initial begin
    in_a  = 1'b0;
    in_b  = 1'b0;
    cnt_q = 8'h00;
  end
  always @(posedge clk) begin
    in_a <= cmd_a;
    if (in_b == cmd_b) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= lag) begin
      in_b  <= cmd_b;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  localparam int unsigned TC     = 10;
  localparam int unsigned LC     = 4;
  localparam int unsigned SETTLE = 4 * LC + 8;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cmd_a = 1'b1;
  logic        cmd_b = 1'b1;
  logic [7:0]  lag = 8'h00;
  logic        chk = 1'b0;
  logic        in_a;
  logic        in_b;
  logic        enable_o;
  logic        disc_err_o;
  logic        fault_o;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] v;
  logic [2:0]  exp_out[$];
  logic [32:0] exp_rd[$];
  int          num_errors = 0;
  int          check_count = 0;

  dcde_pair_model u_pair (.clk(clk), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .lag(lag), .in_a(in_a), .in_b(in_b));
  dcde_eval #(.TICK_CYCLES(TC), .LOGIC_CYCLES(LC)) dut (
    .clk(clk), .sys_rst(sys_rst), .in_a(in_a), .in_b(in_b),
    .enable_o(enable_o), .disc_err_o(disc_err_o), .fault_o(fault_o),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Expected is {enable, discrepancy error, fault}
  task automatic step(input logic a, input logic b, input int w,
                      input logic [2:0] e);
    @(posedge clk);
    cmd_a <= a;
    cmd_b <= b;
    repeat (SETTLE + w) @(posedge clk);
    exp_out.push_back(e);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // ------------------------------------------------------------
  // Monitor
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (chk) check({30'h0, enable_o, disc_err_o, fault_o},
                   {30'h0, exp_out.pop_front()});
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, exp_rd.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0DA4));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(dcde_pkg::ADDR_CTRL, {1'b0, 32'h2});
    rd(dcde_pkg::ADDR_DISC, {1'b0, 32'h0});
    rd(8'h10, {1'b1, 32'h0});
    step(1'b1, 1'b1, 0, 3'b001);
    step(1'b0, 1'b0, 0, 3'b001);
    step(1'b1, 1'b1, 0, 3'b100);
    step(1'b1, 1'b0, 80, 3'b000);
    step(1'b1, 1'b1, 0, 3'b001);
    step(1'b0, 1'b0, 0, 3'b001);
    step(1'b1, 1'b1, 0, 3'b100);
    done("equivalent");
    // Thirty clocks, well above one evaluation cycle
    apb(1'b1, dcde_pkg::ADDR_DISC, 32'h3);
    lag <= 8'h03;
    step(1'b0, 1'b1, 80, 3'b011);
    step(1'b0, 1'b0, 0, 3'b011);
    step(1'b1, 1'b1, 0, 3'b100);
    done("timeout");
    apb(1'b1, dcde_pkg::ADDR_DISC, 32'h0);
    step(1'b0, 1'b0, 0, 3'b000);
    apb(1'b1, dcde_pkg::ADDR_CTRL, 32'h3);
    step(1'b0, 1'b1, 0, 3'b000);
    apb(1'b1, dcde_pkg::ADDR_DISC, 32'h3);
    step(1'b1, 1'b0, 0, 3'b100);
    step(1'b1, 1'b1, 80, 3'b011);
    step(1'b0, 1'b1, 0, 3'b011);
    step(1'b1, 1'b0, 0, 3'b100);
    done("complementary");
    apb(1'b1, dcde_pkg::ADDR_CTRL, 32'h1);
    step(1'b1, 1'b1, 80, 3'b001);
    step(1'b0, 1'b1, 0, 3'b001);
    step(1'b1, 1'b0, 0, 3'b100);
    done("one_output");
    apb(1'b1, dcde_pkg::ADDR_CTRL, 32'h6);
    step(1'b0, 1'b1, 0, 3'b000);
    step(1'b1, 1'b0, 80, 3'b100);
    rd(dcde_pkg::ADDR_INPUTS, {1'b0, 32'h1});
    done("single_source");
    // Values above the largest legal time are stored clipped
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 12'hBB9 : 12'($urandom);
      apb(1'b1, dcde_pkg::ADDR_DISC, {20'h0, v});
      rd(dcde_pkg::ADDR_DISC,
         {21'h0, (v > 12'hBB8) ? 12'hBB8 : v});
    end
    done("config");
    end_of_test();
  end
endmodule
